// >>> src/iep_dev.sv
/*
  device end of an interrupt IN pipe: declares its poll period, answers a
  token with data, a zero-length packet or NAK.
  assumes the host end across iep_if; payload arrives on a byte stream.
  limitation: a high bandwidth pipe gets one packet per poll; the byte cap per
  microframe is reckoned over the device's own microframe count, which is not
  locked to the host's schedule, so a cap can land up to one microframe off.
*/
// What this block does
// RL1: full speed period code one to 255
// RL2: low speed period code ten to 255
// RL3: high speed period is 2^(N-1) microframes
// RL4: host spacing never under one slot
// RL5: host polls within the desired period
// RL6: host polls only with request pending
// RL7: pending request served in next slot
// RL8: high speed at most 3072 bytes per microframe
// RL9: over 1024 bytes means several transactions; the code sends one packet of at most 1024 bytes per poll
// RL10: high bandwidth declares period code one
// RL11: no data at poll answers NAK; code sends a zero-length packet with an event pending and an empty buffer
// RL12: send data only when event pending
// RL13: zero-length packet is a complete transfer
// RL14: full speed budget adds 13 overhead bytes
// RL15: high speed overhead fields per transaction
// RL16: high speed budget at 480 Mb/s
// RL17: periodic share at most 80 percent high speed
// RL18: periodic share at most 90 percent otherwise
// RL19: after NAK host keeps request, retries
`timescale 1ns/1ps
`include "iep_map.svh"
module iep_dev
  import iep_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // link
  iep_if.dev               lnk,
  // configuration
  input  wire iep_speed_t  cfg_speed,
  input  wire logic [7:0]  cfg_period,
  input  wire logic [11:0] cfg_len,
  // event source
  input  wire logic        evt_pending,
  input  wire logic [7:0]  src_byte,
  input  wire logic        src_vld,
  output      logic        src_rdy,
  output      logic        cfg_err
);
  typedef enum logic [1:0] {
    IEP_ST_IDLE = 2'b00,
    IEP_ST_SEND = 2'b01
  } iep_dev_state_t;

  typedef struct packed {
    iep_dev_state_t state;
    logic [7:0]     code;
    iep_speed_t     spd;
    logic           hb;
    logic [11:0]    left;
    logic [11:0]    uf_bytes;
    logic [23:0]    uf_tick;
    logic [1:0]     ans;
    logic           ans_vld;
    logic           zlp;
    logic           err;
  } iep_dev_t;

  iep_dev_t st_r;
  iep_dev_t st_nxt;

  logic [8:0] buf_out;
  logic       buf_vld;
  logic       buf_in_rdy;
  logic       snd_pop;
  logic       snd_end;

  // ************************************************************
  // payload buffer
  // ************************************************************
  // two entries so a stalled link loses no byte already taken from the source;
  // the ninth bit is spare and always zero
  iep_skid iep_skid_i (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   ({1'b0, src_byte}),
    .in_valid  (src_vld),
    .in_ready  (buf_in_rdy),
    .out_data  (buf_out),
    .out_valid (buf_vld),
    .out_ready (snd_pop)
  );

  // a byte leaves only while a packet is open and the host can take it
  assign snd_pop = (st_r.state == IEP_ST_SEND) && lnk.dat_rdy && buf_vld;

  // ************************************************************
  // packet end
  // ************************************************************
  // the last counted byte or the microframe cap closes the packet; both must
  // raise dat_last, or the host would wait on a byte that never comes
  assign snd_end = (st_r.left == 12'h001) ||
                   (st_r.uf_bytes + 12'h001 >= `IEP_HS_UFRAME_MAX);            // [RL8]

  // period code clamp to the legal range of the speed
  function automatic logic [7:0] iep_clamp(input iep_speed_t s, input logic [7:0] c,
                                           input logic hb);
    if (s == IEP_SPD_HIGH) begin
      if (hb)                         iep_clamp = `IEP_HB_PER;      // [RL10]
      else if (c < `IEP_HS_PER_MIN)   iep_clamp = `IEP_HS_PER_MIN;  // [RL3]
      else if (c > `IEP_HS_PER_MAX)   iep_clamp = `IEP_HS_PER_MAX;
      else                            iep_clamp = c;
    // an 8-bit code cannot pass 255, so low and full speed need no upper clamp
    end else if (s == IEP_SPD_LOW) begin
      iep_clamp = (c < `IEP_LS_PER_MIN) ? `IEP_LS_PER_MIN : c;      // [RL2]
    end else begin
      iep_clamp = (c < `IEP_FS_PER_MIN) ? `IEP_FS_PER_MIN : c;      // [RL1]
    end
  endfunction : iep_clamp

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic        hb;
    logic [11:0] pkt;
    hb     = 1'b0;
    pkt    = `IEP_BYTE_RST;
    st_nxt = st_r;
    st_nxt.ans_vld = 1'b0;
    st_nxt.zlp     = 1'b0;
    // more than one max packet per period needs several transactions
    hb = (cfg_speed == IEP_SPD_HIGH) && (cfg_len > `IEP_HS_MAXPKT);  // [RL9]
    st_nxt.hb   = hb;
    st_nxt.spd  = cfg_speed;
    st_nxt.code = iep_clamp(cfg_speed, cfg_period, hb);
    st_nxt.err  = (cfg_speed == IEP_SPD_HIGH) && (cfg_len > `IEP_HS_UFRAME_MAX);
    // per-transaction packet cap by speed
    unique case (cfg_speed)
      IEP_SPD_HIGH: pkt = `IEP_HS_MAXPKT;
      IEP_SPD_FULL: pkt = `IEP_FS_MAXPKT;
      default:      pkt = `IEP_LS_MAXPKT;
    endcase
    unique case (st_r.state)
      IEP_ST_IDLE: begin
        if (lnk.poll) begin
          st_nxt.ans_vld = 1'b1;
          if (!evt_pending) begin
            st_nxt.ans = IEP_ANS_NAK;                                // [RL11] [RL12]
          end else if (!buf_vld || cfg_len == `IEP_BYTE_RST) begin
            st_nxt.ans = IEP_ANS_DATA;                               // [RL13]
            st_nxt.zlp = 1'b1;
          end else begin
            st_nxt.ans   = IEP_ANS_DATA;
            st_nxt.left  = (cfg_len < pkt) ? cfg_len : pkt;
            st_nxt.state = IEP_ST_SEND;
          end
        end
      end
      IEP_ST_SEND: begin
        if (snd_pop) begin
          st_nxt.left     = st_r.left - 12'h001;
          st_nxt.uf_bytes = st_r.uf_bytes + 12'h001;
          // last counted byte or microframe byte cap ends the packet
          if (snd_end) begin                                         // [RL8]
            st_nxt.state = IEP_ST_IDLE;
          end
        end
      end
      default: st_nxt.state = IEP_ST_IDLE;
    endcase
    if (lnk.poll && !st_r.hb) st_nxt.uf_bytes = `IEP_BYTE_RST;
    // own microframe count: a high bandwidth pipe never clears on a poll, so
    // without this its byte count would only grow and choke every later packet
    if (st_r.uf_tick + 24'h000001 >= iep_slot_len(IEP_SPD_HIGH)) begin  // [RL8]
      st_nxt.uf_tick  = `IEP_SLOT_CNT_RST;
      st_nxt.uf_bytes = `IEP_BYTE_RST;
    end else begin
      st_nxt.uf_tick  = st_r.uf_tick + 24'h000001;
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // declared configuration, all registered
  assign lnk.poll_period_code = st_r.code;
  assign lnk.speed            = st_r.spd;
  assign lnk.hb_mode          = st_r.hb;

  // answer to a token; ans_vld and zlp are one-cycle pulses, ans holds
  assign lnk.ans              = iep_ans_t'(st_r.ans);
  assign lnk.ans_vld          = st_r.ans_vld;
  assign lnk.zlp              = st_r.zlp;

  // payload stream; valid is combinational so a byte moves in the cycle it pops
  assign lnk.dat              = buf_out[7:0];
  assign lnk.dat_vld          = snd_pop;
  assign lnk.dat_last         = snd_pop && snd_end;

  // local status
  assign src_rdy              = buf_in_rdy;
  assign cfg_err              = st_r.err;
endmodule : iep_dev

// >>> src/iep_host.sv
/*
  host end: polls the endpoint only while a client request is pending,
  at most every desired period and never faster than one slot.
  assumes the device end across iep_if and a client request port.
*/
`timescale 1ns/1ps
`include "iep_map.svh"
module iep_host
  import iep_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // link
  iep_if.host             lnk,
  // client side
  input  wire logic       client_transfer_request,
  input  wire logic       bus_error,
  output      logic       req_done,
  output      logic       req_nak,
  output      logic [7:0] rx_byte,
  output      logic       rx_vld,
  output      logic       rx_last,
  output      logic [15:0] slot_budget
);
  typedef struct packed {
    logic [23:0] tick;
    logic [23:0] slots;
    logic        pend;
    logic        wait_ans;
    logic        poll;
    logic        done;
    logic        nak;
    logic [7:0]  rxb;
    logic        rxv;
    logic        rxl;
    logic [15:0] budget;
  } iep_host_t;

  iep_host_t st_r;
  iep_host_t st_nxt;

  // ************************************************************
  // schedule and answer handling
  // ************************************************************
  always_comb begin
    logic [15:0] ovh;
    logic [15:0] cap;
    ovh    = 16'h0000;
    cap    = 16'h0000;
    st_nxt = st_r;
    st_nxt.poll = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.nak  = 1'b0;
    st_nxt.rxv  = 1'b0;
    st_nxt.rxl  = 1'b0;
    if (client_transfer_request) st_nxt.pend = 1'b1;
    // slot clock; period in slots, polled once per period (at or under)
    if (st_r.tick + 24'h000001 >= iep_slot_len(lnk.speed)) begin   // [RL4]
      st_nxt.tick = `IEP_SLOT_CNT_RST;
      if (st_r.slots + 24'h000001 >= iep_period_slots(lnk.speed, lnk.poll_period_code)) begin
        st_nxt.slots = `IEP_SLOT_CNT_RST;                           // [RL5]
        // no pending request: slot passes with no token
        if (st_nxt.pend && !st_r.wait_ans && !bus_error) begin     // [RL6] [RL7]
          st_nxt.poll     = 1'b1;
          st_nxt.wait_ans = 1'b1;
        end
      end else begin
        st_nxt.slots = st_r.slots + 24'h000001;
      end
    end else begin
      st_nxt.tick = st_r.tick + 24'h000001;
    end
    // answer from the endpoint
    if (st_r.wait_ans && lnk.ans_vld) begin
      if (lnk.ans == IEP_ANS_NAK) begin
        st_nxt.nak      = 1'b1;                                     // [RL19]
        st_nxt.wait_ans = 1'b0;
      end else if (lnk.zlp) begin
        st_nxt.done     = 1'b1;                                     // [RL13]
        st_nxt.pend     = client_transfer_request;
        st_nxt.wait_ans = 1'b0;
      end
    end
    if (st_r.wait_ans && lnk.dat_vld) begin
      st_nxt.rxb = lnk.dat;
      st_nxt.rxv = 1'b1;
      st_nxt.rxl = lnk.dat_last;
      if (lnk.dat_last) begin
        st_nxt.done     = 1'b1;
        st_nxt.pend     = client_transfer_request;
        st_nxt.wait_ans = 1'b0;
      end
    end
    // periodic budget: overhead plus max packet, share of the slot
    if (lnk.speed == IEP_SPD_HIGH) begin
      ovh = `IEP_HS_OVH + 16'(`IEP_HS_MAXPKT);                      // [RL15] [RL16]
      cap = 16'((32'(`IEP_HS_BUDGET) * 32'(`IEP_HS_PCT)) / 32'(`IEP_PCT_FULL)); // [RL17]
    end else begin
      ovh = `IEP_FS_OVH + 16'(`IEP_FS_MAXPKT);                      // [RL14]
      cap = 16'((32'(`IEP_FS_BUDGET) * 32'(`IEP_FS_PCT)) / 32'(`IEP_PCT_FULL)); // [RL18]
    end
    st_nxt.budget = (ovh <= cap) ? cap - ovh : 16'h0000;
  end

  // register stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.poll    = st_r.poll;
  assign lnk.dat_rdy = 1'b1;       // host always sinks; the client side has no stall input
  assign req_done    = st_r.done;
  assign req_nak     = st_r.nak;
  assign rx_byte     = st_r.rxb;
  assign rx_vld      = st_r.rxv;
  assign rx_last     = st_r.rxl;
  assign slot_budget = st_r.budget;
endmodule : iep_host

// >>> src/iep_if.sv
/*
  link between host poller and endpoint: poll token, answer, byte stream.
  assumes one shared clock; no tristate wires on this link.
*/
`timescale 1ns/1ps
interface iep_if (
  input wire logic clk
);
  import iep_pkg::*;
  logic [7:0]  poll_period_code;   // declared desired period
  iep_speed_t  speed;              // declared speed
  logic        hb_mode;            // endpoint is high bandwidth
  logic        poll;               // one-cycle token
  iep_ans_t    ans;                // answer, valid with ans_vld
  logic        ans_vld;
  logic [7:0]  dat;                // payload byte stream
  logic        dat_vld;
  logic        dat_last;           // last byte of packet
  logic        dat_rdy;
  logic        zlp;                // zero-length data packet, with ans_vld

  modport dev (input clk, poll, dat_rdy,
               output poll_period_code, speed, hb_mode, ans, ans_vld, dat, dat_vld,
               dat_last, zlp);
  modport host (input clk, poll_period_code, speed, hb_mode, ans, ans_vld, dat, dat_vld,
                dat_last, zlp,
                output poll, dat_rdy);
endinterface : iep_if

// >>> src/iep_map.svh
/*
  timing, limit and budget constants for the interrupt endpoint polling link.
  assumes a 40 MHz clock; included by the package and design files.
*/
`ifndef IEP_MAP_SVH
`define IEP_MAP_SVH

// ****************************************************************
// clock and time base
// ****************************************************************
`define IEP_CLK_NS          25
`define IEP_UFRAME_NS       125000
`define IEP_FRAME_NS        1000000
`define IEP_UFRAME_CYC      (`IEP_UFRAME_NS / `IEP_CLK_NS)
`define IEP_FRAME_CYC       (`IEP_FRAME_NS / `IEP_CLK_NS)

// ****************************************************************
// poll period code limits
// ****************************************************************
`define IEP_FS_PER_MIN      8'h01
`define IEP_FS_PER_MAX      8'hFF
`define IEP_LS_PER_MIN      8'h0A
`define IEP_LS_PER_MAX      8'hFF
`define IEP_HS_PER_MIN      8'h01
`define IEP_HS_PER_MAX      8'h10
`define IEP_HB_PER          8'h01

// ****************************************************************
// payload limits
// ****************************************************************
`define IEP_HS_MAXPKT       12'h400
`define IEP_HS_UFRAME_MAX   12'hC00
`define IEP_FS_MAXPKT       12'h040
`define IEP_LS_MAXPKT       12'h008

// ****************************************************************
// budgeting overhead in bytes
// ****************************************************************
`define IEP_FS_OVH          16'h000D
`define IEP_HS_SYNC_B       16'h0004
`define IEP_HS_GAP_B        16'h000C
`define IEP_HS_OVH          (16'h0003 * `IEP_HS_SYNC_B + 16'h0003 + 16'h0002 + 16'h0002 \
                             + 16'h0003 * `IEP_HS_GAP_B)
`define IEP_HS_BUDGET       16'h1D4C  // bytes per microframe at 480 Mb/s
`define IEP_FS_BUDGET       16'h05DC
`define IEP_HS_PCT          16'h0050
`define IEP_FS_PCT          16'h005A
`define IEP_PCT_FULL        16'h0064

// ****************************************************************
// default configuration values
// ****************************************************************
`define IEP_CNT_W           24
`define IEP_BYTE_W          12
`define IEP_SLOT_CNT_RST    24'h000000
`define IEP_BYTE_RST        12'h000
`endif

// >>> src/iep_pkg.sv
/*
  types shared by both ends of the interrupt endpoint polling link.
  assumes iep_map.svh is on the include path.
*/
`include "iep_map.svh"
package iep_pkg;
  // bus speed of the pipe
  typedef enum logic [1:0] {
    IEP_SPD_LOW  = 2'b00,
    IEP_SPD_FULL = 2'b01,
    IEP_SPD_HIGH = 2'b10
  } iep_speed_t;

  // answer the endpoint gives to a poll
  typedef enum logic [1:0] {
    IEP_ANS_NONE = 2'b00,
    IEP_ANS_DATA = 2'b01,
    IEP_ANS_NAK  = 2'b10
  } iep_ans_t;

  // slot length in clock cycles for a speed
  function automatic logic [23:0] iep_slot_len(input iep_speed_t spd);
    iep_slot_len = (spd == IEP_SPD_HIGH) ? 24'(`IEP_UFRAME_CYC) : 24'(`IEP_FRAME_CYC);
  endfunction : iep_slot_len

  // desired period in slots: high speed is 2^(n-1) microframes
  function automatic logic [23:0] iep_period_slots(input iep_speed_t spd,
                                                   input logic [7:0] code);
    if (spd == IEP_SPD_HIGH)
      iep_period_slots = 24'h000001 << (code[4:0] - 5'h01);
    else
      iep_period_slots = {16'h0000, code};
  endfunction : iep_period_slots
endpackage : iep_pkg

// >>> src/iep_skid.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module iep_skid
  import iep_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // fill side
  input  wire logic [8:0] in_data,
  input  wire logic       in_valid,
  output      logic       in_ready,
  // drain side
  output      logic [8:0] out_data,
  output      logic       out_valid,
  input  wire logic       out_ready
);
  typedef struct packed {
    logic [1:0][8:0] mem;
    logic            rd;
    logic            wr;
    logic [1:0]      cnt;
  } iep_skid_t;

  iep_skid_t st_r;
  iep_skid_t st_nxt;

  // ************************************************************
  // next state
  // ************************************************************
  // ready from count only so the filler never sees a combinational path
  always_comb begin
    logic push;
    logic pop;
    push   = 1'b0;
    pop    = 1'b0;
    st_nxt = st_r;
    push   = in_valid && (st_r.cnt != 2'h2);
    pop    = out_valid && out_ready;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr           = ~st_r.wr;
    end
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  // register stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready  = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data  = st_r.mem[st_r.rd];
endmodule : iep_skid

// >>> testbench/iep_properties.sv
/*
  checker for the poll link: answer timing, period codes, poll spacing.
  assumes the bench wires link signals and reset in by name.
*/
`timescale 1ns/1ps
module iep_properties
  import iep_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // link
  input wire logic [7:0] poll_period_code,
  input wire iep_speed_t speed,
  input wire logic       hb_mode,
  input wire logic       poll,
  input wire iep_ans_t   ans,
  input wire logic       ans_vld,
  input wire logic       dat_vld,
  input wire logic       zlp
);
  // ************************************************
  // cycles since last token
  // ************************************************
  localparam int HS_GAP = 4999;  // one slot less the token cycle itself
  localparam int FS_GAP = 39999;
  logic [23:0] gap_r;

  // saturates so a long idle span never wraps into a false short gap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_r <= 24'hFFFFFF;
    end else if (poll) begin
      gap_r <= 24'h000000;
    end else if (gap_r != 24'hFFFFFF) begin
      gap_r <= gap_r + 24'h000001;
    end
  end

  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  poll_answer_a: assert property (poll |=> ans_vld)
    else $error("token without answer");
  answer_cause_a: assert property (ans_vld |-> $past(poll))
    else $error("answer without token");
  nak_silent_a: assert property (ans_vld && ans == IEP_ANS_NAK |-> !zlp ##1 (!dat_vld) [*3])
    else $error("data after refusal");
  zlp_data_a: assert property (zlp |-> ans_vld && ans == IEP_ANS_DATA)
    else $error("empty packet not a data answer");
  zlp_empty_a: assert property (ans_vld && zlp |=> !dat_vld)
    else $error("bytes after empty packet");
  hb_code_a: assert property (hb_mode |-> poll_period_code == 8'h01)
    else $error("high bandwidth code not one");
  low_code_a: assert property (!$past(sys_rst) && speed == IEP_SPD_LOW |-> poll_period_code >= 8'h0A)
    else $error("low speed code too small");
  full_code_a: assert property (!$past(sys_rst) && speed == IEP_SPD_FULL |-> poll_period_code != 8'h00)
    else $error("full speed code zero");
  high_code_a: assert property (speed == IEP_SPD_HIGH |-> poll_period_code inside {[8'h01:8'h10]})
    else $error("high speed code out of range");
  hs_spacing_a: assert property (poll && speed == IEP_SPD_HIGH |-> gap_r >= HS_GAP)
    else $error("tokens closer than a microframe");
  fs_spacing_a: assert property (poll && speed != IEP_SPD_HIGH |-> gap_r >= FS_GAP)
    else $error("tokens closer than a frame");
endmodule : iep_properties

// >>> testbench/interrupt_endpoint_polling_test.sv
/*
  bench joining host and device ends; notes expected results in a queue.
  assumes a 40 MHz clock and the package constants of the link.
*/
`timescale 1ns/1ps
module interrupt_endpoint_polling_test
  import iep_pkg::*;
;
  // ************************************************
  // signals and tables
  // ************************************************
  localparam logic [10:0] NAK  = 11'h400;
  localparam logic [10:0] DONE = 11'h600;
  localparam iep_speed_t  T_SPD [9] = '{IEP_SPD_LOW, IEP_SPD_LOW, IEP_SPD_FULL, IEP_SPD_FULL,
    IEP_SPD_HIGH, IEP_SPD_HIGH, IEP_SPD_HIGH, IEP_SPD_HIGH, IEP_SPD_HIGH};
  // code and length in, then hb, error and clamped code out
  localparam logic [19:0] T_CFG [9] = '{20'h03008, 20'hFF008, 20'h00040, 20'hFF040, 20'h00400,
    20'h20400, 20'h05401, 20'h01C00, 20'h01C01};
  localparam logic [9:0]  T_EXP [9] = '{10'h00A, 10'h0FF, 10'h001, 10'h0FF, 10'h001, 10'h010,
    10'h201, 10'h201, 10'h301};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req, bus_error, evt, src_vld, req_done, req_nak, rx_vld, rx_last, src_rdy, cfg_err;
  logic [7:0]  cfg_period, src_byte, rx_byte, src_lfsr, exp_lfsr;
  logic [11:0] cfg_len;
  logic [15:0] slot_budget;
  iep_speed_t  cfg_speed;
  logic [10:0] exp_q [$];
  int          fails, total_checks, cyc, poll_cnt, nak_cnt, last_poll;
  bit          gap_chk;

  iep_if lnk_if (.clk(clk));
  iep_host iep_host_i (.clk(clk), .sys_rst(sys_rst), .lnk(lnk_if), .client_transfer_request(req),
    .bus_error(bus_error), .req_done(req_done), .req_nak(req_nak), .rx_byte(rx_byte),
    .rx_vld(rx_vld), .rx_last(rx_last), .slot_budget(slot_budget));
  iep_dev iep_dev_i (.clk(clk), .sys_rst(sys_rst), .lnk(lnk_if), .cfg_speed(cfg_speed),
    .cfg_period(cfg_period), .cfg_len(cfg_len), .evt_pending(evt), .src_byte(src_byte),
    .src_vld(src_vld), .src_rdy(src_rdy), .cfg_err(cfg_err));
  iep_properties iep_properties_i (.clk(clk), .sys_rst(sys_rst),
    .poll_period_code(lnk_if.poll_period_code), .speed(lnk_if.speed), .hb_mode(lnk_if.hb_mode),
    .poll(lnk_if.poll), .ans(lnk_if.ans), .ans_vld(lnk_if.ans_vld), .dat_vld(lnk_if.dat_vld),
    .zlp(lnk_if.zlp));

  always #12.5 clk = ~clk;

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [7:0] lfsr_next(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next

  task automatic check(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // an unexpected result meets a value no result can carry
  task automatic take(logic [10:0] got);
    logic [10:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 11'h7FF;
    check(got, e);
  endtask : take

  // bytes follow the source sequence in order, then completion
  task automatic note_pkt(int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({2'b01, i == n - 1, exp_lfsr});
      exp_lfsr = lfsr_next(exp_lfsr);
    end
    exp_q.push_back(DONE);
  endtask : note_pkt

  task automatic pulse_req();
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
  endtask : pulse_req

  task automatic drain(int lim);
    for (int n = 0; n < lim && exp_q.size() > 0; n++) @(posedge clk);
    check(exp_q.size(), 0);
  endtask : drain

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // ************************************************
  // source, monitor, watchdog
  // ************************************************
  // source offers a new random byte each time the buffer takes one
  always @(posedge clk) begin
    if (src_vld && src_rdy) begin
      src_lfsr = lfsr_next(src_lfsr);
      src_byte <= src_lfsr;
    end
  end

  // results from the host side against the oldest note
  always @(posedge clk) begin
    if (!sys_rst) begin
      cyc++;
      if (lnk_if.poll) begin
        poll_cnt++;
        if (gap_chk && last_poll != 0) check(cyc - last_poll, 10000);
        last_poll = cyc;
      end
      if (rx_vld) take({2'b01, rx_last, rx_byte});
      if (req_nak) begin
        nak_cnt++;
        take(NAK);
      end
      if (req_done) take(DONE);
    end
  end

  // whole run is about 60000 cycles; cut off at 95000
  initial begin
    #2375000;
    fails++;
    tally_and_finish();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    {req, bus_error, evt, src_vld} = 4'h0;
    cfg_speed = IEP_SPD_HIGH;
    cfg_period = 8'h02;
    cfg_len = 12'h005;
    src_byte = 8'h18;
    src_lfsr = 8'h18;
    exp_lfsr = 8'h18;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // clamped codes, high bandwidth and oversize flag for each setting
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      cfg_speed <= T_SPD[i];
      {cfg_period, cfg_len} <= T_CFG[i];
      repeat (3) @(posedge clk);
      check({lnk_if.hb_mode, cfg_err, lnk_if.poll_period_code}, T_EXP[i]);
      // full frame: 1500 bytes at 90 percent less 13 overhead and 64 payload
      if (T_SPD[i] == IEP_SPD_FULL) check(slot_budget, 16'h04F9);
    end
    @(posedge clk);
    cfg_speed <= IEP_SPD_HIGH;
    {cfg_period, cfg_len} <= 20'h02005;
    // nothing pending: no token at all
    repeat (12000) @(posedge clk);
    check(poll_cnt, 0);
    @(posedge clk) evt <= 1'b1;
    note_pkt(0);
    pulse_req();
    drain(25000);
    @(posedge clk) evt <= 1'b0;
    gap_chk = 1'b1;
    last_poll = 0;
    exp_q.push_back(NAK);
    exp_q.push_back(NAK);
    note_pkt(5);
    pulse_req();
    for (int n = 0; n < 25000 && nak_cnt < 2; n++) @(posedge clk);
    check(nak_cnt, 2);
    @(posedge clk) {evt, src_vld} <= 2'b11;
    repeat (10) @(posedge clk);
    check(src_rdy, 1'b0); // two entries held, source refused
    drain(15000);
    note_pkt(5);
    pulse_req();
    drain(15000);
    @(posedge clk) evt <= 1'b0;
    repeat (20) @(posedge clk);
    check(poll_cnt, 5);
    // microframe: 7500 bytes at 80 percent less 55 overhead and 1024 payload
    check(slot_budget, 16'h1339);
    tally_and_finish();
  end
endmodule : interrupt_endpoint_polling_test
